// [twc_consts.svh]
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TWC_CONSTS_SVH
`define TWC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TWC_OFS_CNT_HI 3'h0
`define TWC_OFS_CNT_LO 3'h1
`define TWC_OFS_PRESC  3'h2
`define TWC_OFS_CTRL   3'h3
`define TWC_OFS_SYS    3'h4

// ----------------------------------------
// System select register fields
// ----------------------------------------
`define TWC_SYS_WD     0
`define TWC_SYS_A0_EXT 1
`define TWC_SYS_TL_EXT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TWC_RST_CNT    16'hffff
`define TWC_RST_PRESC  8'hff
`define TWC_RST_CTRL   8'h12

// ----------------------------------------
// Timing
// ----------------------------------------
// Internal clock divided by 4: last state of a 2-bit divider
`define TWC_DIV_LAST   2'h3

`endif

// [twc_pkg.sv]
// Types shared by the timer/watchdog counter files
package twc_pkg;

  typedef enum logic [1:0] {
    TWC_IN_EVENT  = 2'h0,
    TWC_IN_GATED  = 2'h1,
    TWC_IN_TRIG   = 2'h2,
    TWC_IN_RETRIG = 2'h3
  } twc_in_mode_t;

  typedef enum logic [2:0] {
    TWC_PH_IDLE = 3'h1,
    TWC_PH_WAIT = 3'h2,
    TWC_PH_RUN  = 3'h4
  } twc_phase_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } twc_bus_t;

  typedef struct packed {
    logic         run;
    logic         single;
    twc_in_mode_t in_mode;
    logic         in_en;
    logic         out_mode;
    logic         pwm_level;
    logic         out_en;
  } twc_ctrl_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } twc_sync_t;

  typedef struct packed {
    twc_ctrl_t   ctrl;
    logic [15:0] cnt;
    logic [15:0] cval;
    logic [7:0]  presc;
    logic [7:0]  pcnt;
    logic [1:0]  div;
    twc_phase_t  phase;
    logic        new_c;
    logic        wd;
    logic        a0_ext;
    logic        tl_ext;
    logic [7:0]  rdata;
    logic        out_lvl;
    logic        pin;
    logic        eoc;
    logic        irq_tl;
    logic        irq_a0;
  } twc_state_t;

endpackage

// [twc_in_sync.sv]
// Two-stage synchroniser and falling edge detector for the timer input pin
module twc_in_sync (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall
);

  twc_pkg::twc_sync_t r;
  twc_pkg::twc_sync_t s;

  // --------------------------------------
  // Next state
  // --------------------------------------
  // pin synchronised first
  always_comb begin
    s    = r;
    s.s1 = pin_in;
    s.s2 = r.s1;
    s.s3 = r.s2;
  end

  // Idle high so reset release makes no false edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= 3'h7;
    end else begin
      r <= s;
    end
  end

  assign level = r.s2;
  assign fall  = r.s3 & ~r.s2;

endmodule

// [twc_core.sv]
// Timer/watchdog counter: prescaler, 16-bit down-counter, input modes, output modes
`include "twc_consts.svh"

module twc_core (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire twc_pkg::twc_bus_t bus,
  output logic [7:0]            rdata,
  input  wire logic             timer_input_pin,
  input  wire logic             external_interrupt_input,
  output logic                  timer_output_pin,
  output logic                  irq_top_level,
  output logic                  irq_a0,
  output logic                  end_of_count
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam twc_pkg::twc_state_t RST_STATE = '{
    ctrl:      `TWC_RST_CTRL,
    cnt:       `TWC_RST_CNT,
    cval:      `TWC_RST_CNT,
    presc:     `TWC_RST_PRESC,
    pcnt:      `TWC_RST_PRESC,
    div:       2'h0,
    phase:     twc_pkg::TWC_PH_IDLE,
    new_c:     1'b0,
    wd:        1'b0,
    a0_ext:    1'b0,
    tl_ext:    1'b0,
    rdata:     8'h00,
    out_lvl:   1'b0,
    pin:       1'b1,
    eoc:       1'b0,
    irq_tl:    1'b0,
    irq_a0:    1'b0
  };

  twc_pkg::twc_state_t r;
  twc_pkg::twc_state_t s;

  logic in_lvl;
  logic in_fall;
  logic run_eff;
  logic ext_sel;
  logic div_tick;
  logic tick;
  logic retrig;
  logic step;
  logic eoc_now;
  logic wr_ctrl;

  twc_in_sync u_sync (
    .clock  (clock),
    .rstn   (rstn),
    .pin_in (timer_input_pin),
    .level  (in_lvl),
    .fall   (in_fall)
  );

  // ----------------------------------------
  // Counting clock selection
  // ----------------------------------------
  // watchdog overrides run
  assign run_eff  = r.ctrl.run | r.wd;
  assign ext_sel  = r.ctrl.in_en & ~r.wd;
  // Divider runs free, so the first tick after a start lands within four clocks
  // internal clock by four
  assign div_tick = (r.div == `TWC_DIV_LAST);
  assign wr_ctrl  = bus.wr && (bus.addr == `TWC_OFS_CTRL);

  always_comb begin
    tick = 1'b0;
    if (run_eff && (r.phase == twc_pkg::TWC_PH_RUN)) begin
      if (!ext_sel) begin
        tick = div_tick;
      end else begin
        case (r.ctrl.in_mode)
          twc_pkg::TWC_IN_EVENT: tick = in_fall;
          twc_pkg::TWC_IN_GATED: tick = div_tick & in_lvl;
          default:               tick = div_tick;
        endcase
      end
    end
  end

  assign retrig  = ext_sel && (r.ctrl.in_mode == twc_pkg::TWC_IN_RETRIG) &&
                   run_eff && (r.phase == twc_pkg::TWC_PH_RUN) && in_fall;
  assign step    = tick && !retrig && (r.pcnt == 8'h00);
  assign eoc_now = step && (r.cnt == 16'h0000);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s       = r;
    s.eoc   = eoc_now;
    s.rdata = 8'h00;
    s.div   = r.div + 2'h1;

    // Phase: idle, waiting for trigger, running
    case (r.phase)
      twc_pkg::TWC_PH_IDLE: begin
        if (run_eff) begin
          if (ext_sel && (r.ctrl.in_mode == twc_pkg::TWC_IN_TRIG)) begin
            s.phase = twc_pkg::TWC_PH_WAIT;
          end else begin
            s.phase = twc_pkg::TWC_PH_RUN;
          end
          if (r.new_c) begin
            s.cnt   = r.cval;
            s.pcnt  = r.presc;
            s.new_c = 1'b0;
          end
        end
      end
      twc_pkg::TWC_PH_WAIT: begin
        if (!run_eff) begin
          s.phase = twc_pkg::TWC_PH_IDLE;
        end else if (in_fall || !(ext_sel && (r.ctrl.in_mode == twc_pkg::TWC_IN_TRIG))) begin
          // Watchdog or a mode change must not park the counter here
          s.phase = twc_pkg::TWC_PH_RUN;
        end
      end
      twc_pkg::TWC_PH_RUN: begin
        if (!run_eff) begin
          s.phase = twc_pkg::TWC_PH_IDLE;
        end
      end
      default: s.phase = twc_pkg::TWC_PH_IDLE;
    endcase

    if (retrig) begin
      s.cnt   = r.cval;
      s.pcnt  = r.presc;
      s.new_c = 1'b0;
    end else if (tick) begin
      if (r.pcnt == 8'h00) begin
        s.pcnt = r.presc;
        if (eoc_now) begin
          s.cnt   = r.cval;
          s.new_c = 1'b0;
        end else begin
          s.cnt = r.cnt - 16'h0001;
        end
      end else begin
        s.pcnt = r.pcnt - 8'h01;
      end
    end

    if (eoc_now) begin
      if (r.ctrl.single && !r.wd) begin
        s.ctrl.run = 1'b0;
        s.phase    = twc_pkg::TWC_PH_IDLE;
      end
      if (r.ctrl.out_mode) begin
        s.out_lvl = r.ctrl.pwm_level;
      end else begin
        s.out_lvl = ~r.out_lvl;
      end
    end

    // Software writes win over hardware updates
    if (bus.wr) begin
      case (bus.addr)
        `TWC_OFS_CNT_HI: begin
          if (!r.wd) begin
            s.cval[15:8] = bus.wdata;
            s.new_c      = 1'b1;
          end
        end
        `TWC_OFS_CNT_LO: begin
          if (!r.wd) begin
            s.cval[7:0] = bus.wdata;
            s.new_c     = 1'b1;
          end
        end
        `TWC_OFS_PRESC: begin
          s.presc = bus.wdata;
          s.pcnt  = bus.wdata;
        end
        `TWC_OFS_CTRL: s.ctrl = twc_pkg::twc_ctrl_t'(bus.wdata);
        `TWC_OFS_SYS: begin
          // Watchdog mode cannot be left once entered
          s.wd     = r.wd | bus.wdata[`TWC_SYS_WD];
          s.a0_ext = bus.wdata[`TWC_SYS_A0_EXT];
          s.tl_ext = bus.wdata[`TWC_SYS_TL_EXT];
        end
        default: s.wd = r.wd;
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        // Counter reads show the live count
        `TWC_OFS_CNT_HI: s.rdata = r.cnt[15:8];
        `TWC_OFS_CNT_LO: s.rdata = r.cnt[7:0];
        `TWC_OFS_PRESC:  s.rdata = r.presc;
        `TWC_OFS_CTRL:   s.rdata = r.ctrl;
        `TWC_OFS_SYS:    s.rdata = {5'h00, r.tl_ext, r.a0_ext, r.wd};
        default:         s.rdata = 8'h00;
      endcase
    end

    s.pin = s.ctrl.out_en ? s.out_lvl : 1'b1;

    s.irq_tl = r.tl_ext ? external_interrupt_input : eoc_now;
    s.irq_a0 = r.a0_ext ? external_interrupt_input : eoc_now;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= RST_STATE;
    end else begin
      r <= s;
    end
  end

  assign rdata            = r.rdata;
  assign timer_output_pin = r.pin;
  assign irq_top_level    = r.irq_tl;
  assign irq_a0           = r.irq_a0;
  assign end_of_count     = r.eoc;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_eoc_reload_const: assert property (
    r.eoc |-> r.cnt == $past(r.cval))
    else $error("count not reloaded at end of count");

  a_single_stop_run: assert property (
    r.eoc && $past(r.ctrl.single && !r.wd) && !$past(wr_ctrl) |-> !r.ctrl.run)
    else $error("single mode did not clear run");

  a_stop_hold_count: assert property (
    !run_eff && !(bus.wr && bus.addr == `TWC_OFS_PRESC) |=> $stable(r.cnt))
    else $error("counter moved while stopped");

  a_out_idle_high: assert property (
    !r.ctrl.out_en |-> timer_output_pin)
    else $error("disabled output not high");

  a_square_toggle: assert property (
    r.eoc && !$past(r.ctrl.out_mode) |-> r.out_lvl != $past(r.out_lvl))
    else $error("square wave did not toggle");

  a_pwm_level_copy: assert property (
    r.eoc && $past(r.ctrl.out_mode) |-> r.out_lvl == $past(r.ctrl.pwm_level))
    else $error("PWM level not copied");

  a_presc_wrap_load: assert property (
    step && !(bus.wr && bus.addr == `TWC_OFS_PRESC) |=> r.pcnt == $past(r.presc))
    else $error("prescaler not reloaded on wrap");

  a_internal_div_four: assert property (
    tick && !ext_sel |=> !tick [*3])
    else $error("internal tick faster than clock by four");

  a_wd_forces_run: assert property (
    r.wd ##1 r.wd |-> r.phase == twc_pkg::TWC_PH_RUN)
    else $error("watchdog mode not counting");

  a_irq_route_timer: assert property (
    $past(!r.tl_ext) |-> irq_top_level == end_of_count)
    else $error("top-level interrupt not from end of count");

  a_run_starts_next: assert property (
    run_eff && (r.phase == twc_pkg::TWC_PH_IDLE) && !ext_sel |=> r.phase == twc_pkg::TWC_PH_RUN)
    else $error("run bit did not start counting");

  a_retrig_reload: assert property (
    retrig |=> r.cnt == $past(r.cval))
    else $error("retrigger did not reload constant");

  a_event_step_down: assert property (
    tick && ext_sel && (r.ctrl.in_mode == twc_pkg::TWC_IN_EVENT) && (r.pcnt == 8'h00) |=>
    r.eoc || (r.cnt == $past(r.cnt) - 16'h0001))
    else $error("event did not step the counter");

  c_single_eoc:  cover property (r.eoc && !r.ctrl.run);
  c_retrig_load: cover property (retrig);
  c_pwm_eoc:     cover property (r.eoc && r.ctrl.out_en && r.ctrl.out_mode);
  c_trig_start:  cover property (r.phase == twc_pkg::TWC_PH_WAIT ##1
                                 r.phase == twc_pkg::TWC_PH_RUN);
  c_wd_eoc:      cover property (r.eoc && r.wd);

endmodule

// [twc_src_model.sv]
// Behavioural signal source standing on the timer input pin
module twc_src_model (
  input  wire logic clock,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin = 1'b1;

  task automatic pulses(input int n, input int gap);
    int g;
    g = (gap < 8) ? 8 : gap;
    repeat (n) begin
      @(posedge clock);
      pin <= 1'b0;
      repeat (g / 2) @(posedge clock);
      pin <= 1'b1;
      repeat (g - g / 2 - 1) @(posedge clock);
    end
  endtask

  task automatic level(input logic v);
    @(posedge clock);
    pin <= v;
  endtask
endmodule

// [timer_watchdog_counter_tb_top.sv]
// Self-checking bench for the timer/watchdog counter
`include "twc_consts.svh"
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); \
  end \
end

module timer_watchdog_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock;
  logic              rstn;
  twc_pkg::twc_bus_t bus;
  logic [7:0]        rdata;
  logic              pin_in;
  logic              ext_in;
  logic              out_pin;
  logic              irq_tl;
  logic              irq_a0;
  logic              eoc;
  logic [7:0]        v;
  logic              o1;
  int                bad_count = 0;
  int                checks = 0;
  int                eocs = 0;
  int                cyc = 0;
  int                n;

  twc_core dut (
    .clock                    (clock),
    .rstn                     (rstn),
    .bus                      (bus),
    .rdata                    (rdata),
    .timer_input_pin          (pin_in),
    .external_interrupt_input (ext_in),
    .timer_output_pin         (out_pin),
    .irq_top_level            (irq_tl),
    .irq_a0                   (irq_a0),
    .end_of_count             (eoc)
  );

  twc_src_model src (
    .clock (clock),
    .pin   (pin_in)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clock);
      #1;
    end
  endtask

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick(1);
    bus <= '0;
    tick(1);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    tick(1);
    bus <= '0;
    d = rdata;
    tick(1);
  endtask

  task automatic wait_eoc(input int lim, output int k);
    k = 0;
    while (eoc !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
  endtask

  // Stopping first makes the new constant load at restart
  task automatic cfg(input logic [7:0] lo, input logic [7:0] p, input logic [7:0] c);
    wr(`TWC_OFS_CTRL, 8'h00);
    wr(`TWC_OFS_CNT_HI, 8'h00);
    wr(`TWC_OFS_CNT_LO, lo);
    wr(`TWC_OFS_PRESC, p);
    wr(`TWC_OFS_CTRL, c);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (eoc === 1'b1) eocs++;
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    bus = '0;
    ext_in = 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    tick(1);
    `CHK(out_pin, 1'b1) // disabled output high
    rd(`TWC_OFS_CTRL, v);
    `CHK(v, `TWC_RST_CTRL) // control reset value
    rd(`TWC_OFS_CNT_HI, v);
    `CHK(v, 8'hff) // counter reset value
    rd(`TWC_OFS_PRESC, v);
    `CHK(v, `TWC_RST_PRESC) // prescaler reset value
    rd(3'h5, v);
    `CHK(v, 8'h00) // unmapped reads zero
    // Continuous square wave, half period (2+1)*(1+1)*4
    cfg(8'h02, 8'h01, 8'h81);
    wait_eoc(100, n);
    `CHK(irq_tl, 1'b1) // interrupt at end of count
    `CHK(irq_a0, 1'b1) // channel A0 takes end of count
    o1 = out_pin;
    tick(1);
    wait_eoc(100, n);
    `CHK(n + 1, 24) // period from prescaler and counter
    `CHK(out_pin, ~o1) // output toggles
    // Single mode set with the run bit
    wr(`TWC_OFS_CTRL, 8'hC1);
    wait_eoc(100, n);
    tick(1);
    rd(`TWC_OFS_CTRL, v);
    `CHK(v, 8'h41) // run bit cleared
    wait_eoc(60, n);
    `CHK(n, 60) // counter stays stopped
    // PWM level copied at end of count
    wr(`TWC_OFS_CTRL, 8'h85);
    wait_eoc(100, n);
    `CHK(out_pin, 1'b0) // level zero copied
    tick(1);
    wr(`TWC_OFS_CTRL, 8'h87);
    wait_eoc(100, n);
    `CHK(out_pin, 1'b1) // level one copied
    // Stopped right after a reload, before the next step
    wr(`TWC_OFS_CTRL, 8'h00);
    rd(`TWC_OFS_CNT_LO, v);
    `CHK(v, 8'h02) // count held while stopped
    // Event counting, every fourth falling edge ends the count
    cfg(8'h03, 8'h00, 8'h88);
    n = eocs;
    src.pulses(8, 10);
    tick(6);
    `CHK(eocs - n, 2) // falling edges counted
    // Gated counting
    src.level(1'b0);
    tick(1);
    cfg(8'h00, 8'h00, 8'h98);
    n = eocs;
    tick(40);
    `CHK(eocs - n, 0) // paused while low
    src.level(1'b1);
    tick(40);
    `CHK(eocs - n > 7, 1'b1) // counts while high
    // Triggerable start
    cfg(8'h00, 8'h00, 8'hA8);
    n = eocs;
    tick(40);
    `CHK(eocs - n, 0) // waits for trigger edge
    src.pulses(1, 8);
    tick(20);
    `CHK(eocs - n > 2, 1'b1) // runs after edge
    // Retriggered faster than the 40-cycle period
    cfg(8'h09, 8'h00, 8'hB8);
    n = eocs;
    src.pulses(6, 16);
    `CHK(eocs - n, 0) // edges restart count
    tick(50);
    `CHK(eocs - n > 0, 1'b1) // count ends without edges
    // Interrupts routed to the external input
    wr(`TWC_OFS_CTRL, 8'h00);
    ext_in <= 1'b1;
    wr(`TWC_OFS_SYS, 8'h06);
    tick(2);
    `CHK(irq_a0, 1'b1) // channel takes external input
    `CHK(irq_tl, 1'b1) // top level takes external input
    // Watchdog mode counts with run bit clear
    wr(`TWC_OFS_SYS, 8'h01);
    wait_eoc(200, n);
    `CHK(n < 200, 1'b1) // run bit ignored
    print_verdict();
  end
endmodule
